// ### rtl/adcsc_pkg.sv
// constants shared by the converter sequencer and its helpers
// assumes one clock where one state equals one clock cycle
`default_nettype none

package adcsc_pkg;
    // register indices on the 8-bit register port
    localparam logic [3:0] CSR_IDX = 4'h0; // control/status
    localparam logic [3:0] TCC_IDX = 4'h1; // trigger/clock control
    localparam logic [3:0] RES_BASE = 4'h2; // result a upper byte
    localparam logic [3:0] RES_END = 4'h9; // result d lower byte
    // control/status bit positions
    localparam int CSR_FLAG = 7;
    localparam int CSR_IE = 6;
    localparam int CSR_RUN = 5;
    localparam int CSR_SCAN = 4;
    localparam int CSR_SET = 3;
    // trigger/clock control fields
    localparam int TCC_SRC_LSB = 6;
    localparam int TCC_CKS_LSB = 2;
    localparam logic [7:0] TCC_ONES = 8'h33; // reserved bits read as one
    // start sources
    localparam logic [1:0] SRC_SW = 2'h0;
    localparam logic [1:0] SRC_TPU = 2'h1;
    localparam logic [1:0] SRC_TMR8 = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // result layout
    localparam int RES_W = 10;
    localparam int RES_REGS = 4;
    localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
    // timing in states, indexed by the clock-select setting
    localparam int STATE_NS = 100;
    localparam int CLK_NS = 100;
    localparam int TD_MIN_STATES [4] = '{18, 10, 6, 4};
    localparam int SPL_STATES [4] = '{127, 63, 31, 15};
    localparam int SCAN_STATES [4] = '{512, 256, 128, 64};
    localparam int STEP_STATES [4] = '{32, 16, 8, 4};
    localparam int TOTAL_MAX_STATES [4] = '{530, 266, 134, 68};

    // states to clock cycles, rounded up, never below one
    function automatic logic [9:0] cyc(input int states);
        int c;
        c = (states * STATE_NS + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return 10'(c);
    endfunction : cyc

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_SAMPLE = 2'b10,
        ST_CONVERT = 2'b11
    } adcsc_state_t;
endpackage : adcsc_pkg

`default_nettype wire

// ### rtl/adcsc_sar_if.sv
// signals between the sequencer and the approximation register
// assumes both ends share core_clk_i
`default_nettype none

interface adcsc_sar_if #(parameter int W = 10);
    logic start; // load the first trial code
    logic step; // decide one bit
    logic comp; // input at or above trial code
    logic [W-1:0] code; // trial code, then result
    logic finished; // all bits decided
    modport ctrl (output start, output step, output comp, input code, input finished);
    modport sar (input start, input step, input comp, output code, output finished);
endinterface : adcsc_sar_if

`default_nettype wire

// ### rtl/adcsc_phase_timer.sv
// down counter timing one phase of a conversion
// assumes load and clock enable come from the sequencer
`default_nettype none

module adcsc_phase_timer #(
    parameter int W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    output logic done_o
);
    logic [W-1:0] count; // cycles left in the phase

    // a phase loaded with n lasts n enabled cycles
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                count <= load_val_i;
            end else if (count != '0) begin
                count <= count - 1'b1;
            end
        end
    end

    // high in the last cycle of the phase
    assign done_o = (count == W'(1));
endmodule : adcsc_phase_timer

`default_nettype wire

// ### rtl/adcsc_sar.sv
// successive approximation register, one bit per step
// assumes the comparator answers within the same cycle
`default_nettype none

module adcsc_sar #(
    parameter int W = 10
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    adcsc_sar_if.sar bus
);
    logic [W-1:0] trial; // one-hot bit under test

    // keep or drop the tested bit, then try the next lower one
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus.code <= '0;
            trial <= '0;
        end else if (ce_i) begin
            if (bus.start) begin
                bus.code <= W'(adcsc_pkg::SAR_MSB);
                trial <= W'(adcsc_pkg::SAR_MSB);
            end else if (bus.step && trial != '0) begin
                bus.code <= (bus.comp ? bus.code : (bus.code & ~trial)) | (trial >> 1);
                trial <= trial >> 1;
            end
        end
    end

    assign bus.finished = (trial == '0);
endmodule : adcsc_sar

`default_nettype wire

// ### rtl/adcsc_top.sv
// converter sequencer: registers, start sources, single and scan runs
// assumes an 8-bit register port with one-cycle read and write strobes,
// triggers and pins synchronous to core_clk_i, one state per clock
//
// Function
// RULE1 - start source field picks the allowed trigger
// RULE2 - software changes start source only when stopped
// RULE3 - reserved control bits read one, ignore writes
// RULE4 - clock select sets maximum conversion time
// RULE5 - software changes clock select only when stopped
// RULE6 - 16-bit results read over 8-bit bus
// RULE7 - upper read copies lower byte into holding
// RULE8 - software reads upper byte before lower byte
// RULE9 - ten-bit approximation, single and scan modes
// RULE10 - software stops conversion before changing mode/channel
// RULE11 - single mode converts selected channel once
// RULE12 - single end sets flag, interrupt if enabled
// RULE13 - run bit cleared by hardware after single
// RULE14 - scan starts at group's first channel
// RULE15 - each scan result stored in own register
// RULE16 - scan group end sets flag, restarts group
// RULE17 - scan repeats while run; clearing stops it
// RULE18 - start delay, then sampling, then conversion
// RULE19 - single timing per clock-select setting
// RULE20 - later scan conversions take fixed time
// RULE21 - external pin falling edge sets run
// RULE22 - flag cleared by read-then-write-zero or transfer
// RULE23 - channel bits pick channel or scan span
// RULE24 - unselected or running-time triggers are ignored
`default_nettype none

module adcsc_top (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [3:0] reg_sel_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic tpu_trig_i,
    input wire logic tmr8_trig_i,
    input wire logic external_trigger_pin_i,
    input wire logic xfer_ack_i,
    input wire logic xfer_count_nonzero_i,
    input wire logic transfer_interrupt_disable_i,
    input wire logic comparator_i,
    output logic [9:0] sar_code_o,
    output logic [3:0] analog_channel_o,
    output logic sample_hold_o,
    output logic conversion_end_interrupt_o
);
    // control/status fields
    logic conversion_end_flag; // set at end of single or scan group
    logic end_interrupt_enable; // gates the interrupt output
    logic conversion_run; // conversion in progress
    logic scan_mode; // 1 scan, 0 single
    logic channel_set_select; // picks channel set 0 or 1
    logic [2:0] channel_sel; // channel or scan span
    logic flag_seen; // flag was read as one since last write
    // trigger/clock control fields
    logic [1:0] start_source; // which trigger may start
    logic [1:0] conv_time_sel; // clock-select setting
    // results and read path
    logic [9:0] result [adcsc_pkg::RES_REGS]; // one per channel slot
    logic [7:0] holding; // lower byte held for the second read
    logic [7:0] next_rdata;
    // sequencer
    adcsc_pkg::adcsc_state_t state;
    adcsc_pkg::adcsc_state_t next_state;
    logic [3:0] cur_ch; // channel being converted
    logic [5:0] step_cnt; // cycles since last approximation step
    logic ext_q; // previous level of the trigger pin
    logic tmr_load;
    logic [9:0] tmr_val;
    logic tmr_done;

    adcsc_sar_if #(.W(adcsc_pkg::RES_W)) sar_bus ();

    // decoded strobes
    logic csr_wr;
    logic tcc_wr;
    logic csr_rd;
    logic res_hit;
    logic [3:0] res_off;
    logic [1:0] res_idx;
    logic ext_fall;
    logic trig_hit;
    logic conv_done;
    logic single_end;
    logic scan_wrap;
    logic flag_set;
    logic flag_clr;
    logic [3:0] first_ch;
    logic [3:0] last_ch;

    assign csr_wr = ce_i && reg_wr_i && reg_sel_i == adcsc_pkg::CSR_IDX;
    assign tcc_wr = ce_i && reg_wr_i && reg_sel_i == adcsc_pkg::TCC_IDX;
    assign csr_rd = ce_i && reg_rd_i && reg_sel_i == adcsc_pkg::CSR_IDX;
    assign res_hit = reg_sel_i >= adcsc_pkg::RES_BASE && reg_sel_i <= adcsc_pkg::RES_END;
    assign res_off = reg_sel_i - adcsc_pkg::RES_BASE;
    assign res_idx = res_off[2:1]; // even offsets upper byte, odd lower

    // group start and last channel; single mode uses the last form too
    assign first_ch = {channel_set_select, channel_sel[2], 2'b00}; // see RULE14
    assign last_ch = {channel_set_select, channel_sel}; // see RULE23

    // the pin idles high; only a falling edge starts anything
    assign ext_fall = ext_q && !external_trigger_pin_i; // see RULE21

    // a trigger counts only from the chosen source and only while stopped
    always_comb begin
        trig_hit = 1'b0;
        case (start_source) // see RULE1
            adcsc_pkg::SRC_TPU: trig_hit = tpu_trig_i;
            adcsc_pkg::SRC_TMR8: trig_hit = tmr8_trig_i;
            adcsc_pkg::SRC_EXT: trig_hit = ext_fall;
            default: trig_hit = 1'b0;
        endcase
        trig_hit = trig_hit && !conversion_run && ce_i; // see RULE24
    end

    // end of a conversion and the two events that raise the flag
    assign conv_done = ce_i && conversion_run && state == adcsc_pkg::ST_CONVERT && tmr_done;
    assign single_end = conv_done && !scan_mode; // see RULE12
    assign scan_wrap = conv_done && scan_mode && cur_ch == last_ch; // see RULE16
    assign flag_set = single_end || scan_wrap;

    // software clear needs an earlier read of one; transfer clear needs count
    assign flag_clr = (csr_wr && !reg_wdata_i[adcsc_pkg::CSR_FLAG] && flag_seen)
        || (ce_i && xfer_ack_i && xfer_count_nonzero_i && !transfer_interrupt_disable_i); // see RULE22

    // pin edge history
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ext_q <= 1'b1;
        end else if (ce_i) begin
            ext_q <= external_trigger_pin_i;
        end
    end

    // end flag: a completing conversion wins over a clear in the same cycle
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conversion_end_flag <= 1'b0;
        end else if (flag_set) begin
            conversion_end_flag <= 1'b1; // see RULE12
        end else if (flag_clr) begin
            conversion_end_flag <= 1'b0; // see RULE22
        end
    end

    // read-as-one memory for the clear; any write to the register consumes it
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flag_seen <= 1'b0;
        end else if (csr_wr) begin
            flag_seen <= 1'b0;
        end else if (csr_rd && conversion_end_flag) begin
            flag_seen <= 1'b1; // see RULE22
        end
    end

    // run bit: software write first, then trigger, then hardware clear
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            conversion_run <= 1'b0;
        end else if (csr_wr) begin
            conversion_run <= reg_wdata_i[adcsc_pkg::CSR_RUN]; // see RULE17
        end else if (trig_hit) begin
            conversion_run <= 1'b1; // see RULE21
        end else if (single_end) begin
            conversion_run <= 1'b0; // see RULE13
        end
    end

    // mode and channel fields; taken as written, software stops first
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            end_interrupt_enable <= 1'b0;
            scan_mode <= 1'b0;
            channel_set_select <= 1'b0;
            channel_sel <= 3'h0;
        end else if (csr_wr) begin
            end_interrupt_enable <= reg_wdata_i[adcsc_pkg::CSR_IE];
            scan_mode <= reg_wdata_i[adcsc_pkg::CSR_SCAN]; // see RULE10
            channel_set_select <= reg_wdata_i[adcsc_pkg::CSR_SET];
            channel_sel <= reg_wdata_i[2:0];
        end
    end

    // start source and clock select; reserved bits have no storage
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            start_source <= adcsc_pkg::SRC_SW;
            conv_time_sel <= 2'h0;
        end else if (tcc_wr) begin
            start_source <= reg_wdata_i[adcsc_pkg::TCC_SRC_LSB +: 2]; // see RULE2
            conv_time_sel <= reg_wdata_i[adcsc_pkg::TCC_CKS_LSB +: 2]; // see RULE5
        end
    end

    // read mux: unmapped indices read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_sel_i == adcsc_pkg::CSR_IDX) begin
            next_rdata = {conversion_end_flag, end_interrupt_enable, conversion_run,
                scan_mode, channel_set_select, channel_sel};
        end else if (reg_sel_i == adcsc_pkg::TCC_IDX) begin
            next_rdata = {start_source, 2'b00, conv_time_sel, 2'b00} | adcsc_pkg::TCC_ONES; // see RULE3
        end else if (res_hit) begin
            // lower byte comes only from the holding register
            next_rdata = res_off[0] ? holding : result[res_idx][9:2]; // see RULE6
        end
    end

    // read data register, updated on each read strobe
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i && reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // upper-byte read captures the lower byte; a lone lower read sees stale data
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            holding <= 8'h00;
        end else if (ce_i && reg_rd_i && res_hit && !res_off[0]) begin
            holding <= {result[res_idx][1:0], 6'h00}; // see RULE7, see RULE8
        end
    end

    // one result register per channel slot, written at conversion end
    for (genvar i = 0; i < adcsc_pkg::RES_REGS; i++) begin : g_res
        always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
                result[i] <= 10'h000;
            end else if (conv_done && cur_ch[1:0] == 2'(i)) begin
                result[i] <= sar_bus.code; // see RULE15
            end
        end
    end

    // phase sequencing; a cleared run bit stops any phase at once
    always_comb begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_val = 10'h000;
        case (state)
            adcsc_pkg::ST_IDLE: begin
                if (conversion_run) begin
                    // the idle cycle counts as the first delay state
                    next_state = adcsc_pkg::ST_DELAY; // see RULE18
                    tmr_load = 1'b1;
                    tmr_val = adcsc_pkg::cyc(adcsc_pkg::TD_MIN_STATES[conv_time_sel] - 1); // see RULE19
                end
            end
            adcsc_pkg::ST_DELAY: begin
                if (!conversion_run) begin
                    next_state = adcsc_pkg::ST_IDLE;
                end else if (tmr_done) begin
                    next_state = adcsc_pkg::ST_SAMPLE;
                    tmr_load = 1'b1;
                    tmr_val = adcsc_pkg::cyc(adcsc_pkg::SPL_STATES[conv_time_sel]); // see RULE19
                end
            end
            adcsc_pkg::ST_SAMPLE: begin
                if (!conversion_run) begin
                    next_state = adcsc_pkg::ST_IDLE;
                end else if (tmr_done) begin
                    // sample plus compare equals the fixed scan time
                    next_state = adcsc_pkg::ST_CONVERT;
                    tmr_load = 1'b1;
                    tmr_val = adcsc_pkg::cyc(adcsc_pkg::SCAN_STATES[conv_time_sel]
                        - adcsc_pkg::SPL_STATES[conv_time_sel]); // see RULE4
                end
            end
            adcsc_pkg::ST_CONVERT: begin
                if (!conversion_run || (tmr_done && !scan_mode)) begin
                    next_state = adcsc_pkg::ST_IDLE; // see RULE13
                end else if (tmr_done) begin
                    // later scan conversions skip the start delay
                    next_state = adcsc_pkg::ST_SAMPLE; // see RULE20
                    tmr_load = 1'b1;
                    tmr_val = adcsc_pkg::cyc(adcsc_pkg::SPL_STATES[conv_time_sel]);
                end
            end
            default: begin
                next_state = adcsc_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= adcsc_pkg::ST_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // channel pointer: group start or single channel, then walk the span
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_ch <= 4'h0;
        end else if (ce_i) begin
            if (state == adcsc_pkg::ST_IDLE) begin
                cur_ch <= scan_mode ? first_ch : last_ch; // see RULE11, see RULE14
            end else if (conv_done && scan_mode) begin
                cur_ch <= (cur_ch == last_ch) ? first_ch : cur_ch + 4'h1; // see RULE16
            end
        end
    end

    // step pacing: ten steps fit inside the shortest compare window
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            step_cnt <= 6'h00;
        end else if (ce_i) begin
            if (state != adcsc_pkg::ST_CONVERT || sar_bus.step) begin
                step_cnt <= 6'h00;
            end else begin
                step_cnt <= step_cnt + 6'h01;
            end
        end
    end

    assign sar_bus.start = ce_i && tmr_load && next_state == adcsc_pkg::ST_CONVERT;
    assign sar_bus.step = state == adcsc_pkg::ST_CONVERT && !sar_bus.finished
        && step_cnt == 6'(adcsc_pkg::STEP_STATES[conv_time_sel] - 1); // see RULE9
    assign sar_bus.comp = comparator_i;

    adcsc_phase_timer #(.W(10)) u_timer (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .load_val_i(tmr_val),
        .done_o(tmr_done)
    );

    adcsc_sar #(.W(adcsc_pkg::RES_W)) u_sar (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .bus(sar_bus.sar)
    );

    // pins toward the analog front end and the interrupt line
    assign sar_code_o = sar_bus.code;
    assign analog_channel_o = cur_ch;
    assign sample_hold_o = state == adcsc_pkg::ST_SAMPLE;
    assign conversion_end_interrupt_o = conversion_end_flag && end_interrupt_enable; // see RULE12

    // checks: enabled cycles spent in the current phase
    logic [9:0] ph_cnt;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_cnt <= 10'h000;
        end else if (ce_i) begin
            ph_cnt <= (next_state != state) ? 10'h000 : ph_cnt + 10'h001;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_reserved_ones: assert property (reg_rd_i && ce_i && reg_sel_i == adcsc_pkg::TCC_IDX
        |=> (reg_rdata_o & 8'h33) == 8'h33) else $error("reserved bits not one"); // see RULE3
    a_upper_copies: assert property (ce_i && reg_rd_i && res_hit && !res_off[0]
        |=> holding[7:6] == $past(result[res_idx][1:0])) else $error("holding not loaded"); // see RULE7
    a_lower_holds: assert property (ce_i && reg_rd_i && res_hit && res_off[0]
        |=> reg_rdata_o == $past(holding)) else $error("lower byte not from holding"); // see RULE7
    a_wrong_source: assert property (ce_i && !conversion_run && !reg_wr_i && start_source == adcsc_pkg::SRC_SW
        |=> !conversion_run) else $error("unselected trigger started"); // see RULE24
    a_ext_start: assert property (ce_i && start_source == adcsc_pkg::SRC_EXT && ext_fall && !reg_wr_i && !conversion_run
        |=> conversion_run) else $error("pin edge did not start"); // see RULE21
    a_single_stop: assert property (single_end && !reg_wr_i
        |=> conversion_end_flag && !conversion_run ##1 state == adcsc_pkg::ST_IDLE)
        else $error("single end wrong"); // see RULE13
    a_flag_wins: assert property (flag_set && flag_clr |=> conversion_end_flag)
        else $error("flag set lost"); // see RULE22
    a_sample_len: assert property (ce_i && state == adcsc_pkg::ST_SAMPLE && next_state == adcsc_pkg::ST_CONVERT
        |-> ph_cnt == 10'(adcsc_pkg::SPL_STATES[conv_time_sel] - 1)) else $error("sample length"); // see RULE19
    a_scan_len: assert property (ce_i && conv_done && scan_mode
        |-> ph_cnt == 10'(adcsc_pkg::SCAN_STATES[conv_time_sel] - adcsc_pkg::SPL_STATES[conv_time_sel] - 1))
        else $error("compare length"); // see RULE20
    a_scan_restart: assert property (scan_wrap && conversion_run && !reg_wr_i
        |=> cur_ch == first_ch && state == adcsc_pkg::ST_SAMPLE) else $error("scan no restart"); // see RULE16

    c_single_done: cover property (single_end);
    c_scan_wrap: cover property (scan_wrap);
    c_ext_start: cover property (ext_fall && trig_hit);
endmodule : adcsc_top

`default_nettype wire

// ### testbench/adcsc_analog_model.sv
// analog source feeding the comparator of the converter
// assumes the comparator is sampled in the cycle the trial code is shown
`default_nettype none

module adcsc_analog_model (
    input wire logic [9:0] code_i,
    input wire logic [3:0] chan_i,
    output logic comp_o
);
    // each channel holds its own level so that results tell channels apart
    always_comb begin
        comp_o = (10'h0a5 + 10'(chan_i) * 10'h111) >= code_i;
    end
endmodule : adcsc_analog_model

`default_nettype wire

// ### testbench/test_adc_sequencer_control.sv
// self-checking bench for the converter sequencer
// assumes one clock, register strobes taken at the edge after they are driven
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; $display("unexpected %0t value", $time); end end

module test_adc_sequencer_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, timer_pulse_unit = 1'b0, tmr = 1'b0, pin = 1'b1, ack = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] wd = 8'h00, rdata;
    logic [9:0] code, v;
    logic [3:0] chan;
    logic comp, sh, irq;
    int fails = 0, n_compared = 0; // mismatches and comparisons
    logic dis = 1'b0; // transfer disable option, raised once to show a refused clear
    // transfer count is held non-zero so the flag clear is allowed
    adcsc_top dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1), .reg_sel_i(sel), .reg_rd_i(rd),
        .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .tpu_trig_i(timer_pulse_unit), .tmr8_trig_i(tmr),
        .external_trigger_pin_i(pin), .xfer_ack_i(ack), .xfer_count_nonzero_i(1'b1),
        .transfer_interrupt_disable_i(dis), .comparator_i(comp), .sar_code_o(code), .analog_channel_o(chan),
        .sample_hold_o(sh), .conversion_end_interrupt_o(irq));
    adcsc_analog_model model_u (.code_i(code), .chan_i(chan), .comp_o(comp));
    // verdict and the single end of the run
    task automatic end_sim();
        if (fails == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // one register access; returns at the edge that takes it
    task automatic acc(input logic w, input logic [3:0] s, input logic [7:0] d);
        @(posedge core_clk_i);
        wr <= w;
        rd <= !w;
        sel <= s;
        wd <= d;
        @(posedge core_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc
    // read with data checked once the registered answer has landed
    task automatic rd_chk(input logic [3:0] s, input logic [7:0] e);
        acc(1'b0, s, 8'h00);
        #1;
        `CHK(rdata, e)
    endtask : rd_chk
    // counts edges until the end interrupt, bounded so a hang ends the run
    task automatic wait_irq(output int n);
        n = 0;
        while (irq !== 1'b1 && n < 1000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n >= 1000) begin
            fails++;
            end_sim();
        end
    endtask : wait_irq
    // one pulse on a start source: 1 timer unit, 2 byte timer, 3 pin low
    task automatic trig(input int s);
        @(posedge core_clk_i);
        timer_pulse_unit <= (s == 1);
        tmr <= (s == 2);
        pin <= (s != 3);
        @(posedge core_clk_i);
        timer_pulse_unit <= 1'b0;
        tmr <= 1'b0;
        pin <= 1'b1;
    endtask : trig
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        int n;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        rd_chk(4'h0, 8'h00);
        rd_chk(4'h1, 8'h33);
        acc(1'b1, 4'h1, 8'hcc);
        rd_chk(4'h1, 8'hff);
        // single run on channel 1 at the fastest setting
        acc(1'b1, 4'h1, 8'h0c);
        acc(1'b1, 4'h0, 8'h61);
        wait_irq(n);
        `CHK(n, 68)
        rd_chk(4'h0, 8'hc1);
        v = 10'h1b6;
        rd_chk(4'h4, v[9:2]);
        rd_chk(4'h5, {v[1:0], 6'h00});
        acc(1'b1, 4'h0, 8'h41);
        #1;
        `CHK(irq, 1'b0)
        // hardware sources: a foreign pulse is ignored, the chosen one starts
        for (int s = 1; s < 4; s++) begin
            acc(1'b1, 4'h1, {2'(s), 6'h0c});
            trig(s == 1 ? 2 : 1);
            repeat (80) @(posedge core_clk_i);
            `CHK(irq, 1'b0)
            trig(s);
            wait_irq(n);
            `CHK(n inside {[66:70]}, 1'b1)
            rd_chk(4'h0, 8'hc1);
            acc(1'b1, 4'h0, 8'h41);
        end
        // scan over channels 0 to 2, later conversions at the fixed length
        acc(1'b1, 4'h1, 8'h0c);
        acc(1'b1, 4'h0, 8'h72);
        wait_irq(n);
        `CHK(n, 196)
        for (int c = 0; c < 3; c++) begin
            v = 10'h0a5 + 10'(c) * 10'h111;
            rd_chk(4'(2 + 2 * c), v[9:2]);
            rd_chk(4'(3 + 2 * c), {v[1:0], 6'h00});
        end
        `CHK(chan, 4'h0)
        // a service with the disable option set must leave the flag alone
        @(posedge core_clk_i);
        ack <= 1'b1;
        dis <= 1'b1;
        @(posedge core_clk_i);
        ack <= 1'b0;
        dis <= 1'b0;
        #1;
        `CHK(irq, 1'b1)
        @(posedge core_clk_i);
        ack <= 1'b1;
        @(posedge core_clk_i);
        ack <= 1'b0;
        #1;
        `CHK(irq, 1'b0)
        acc(1'b1, 4'h0, 8'h52);
        // the running phase is left one edge after the stop is taken
        @(posedge core_clk_i);
        #1;
        `CHK(sh, 1'b0)
        rd_chk(4'h0, 8'h52);
        end_sim();
    end
endmodule : test_adc_sequencer_control

`default_nettype wire
